/* File: rbsw_bank_window.sv */
/*
 * Window end: holds the bank select register and maps CPU accesses onto
 * the flash array, the window 8000h-bfffh through the chosen bank.
 * Assumes the flash array answers combinationally from its address, on
 * the same clock, and that every request on the link is answered once.
 */
`timescale 1ns/1ps
`include "rbsw_defines.svh"

module rbsw_bank_window #(
	parameter int BANK_COUNT = `RBSW_BANKS_LARGE
) (
	// Clock, reset, enable
	input  logic                          clk_i,
	input  logic                          rst_i,
	input  logic                          ce_i,
	// CPU link
	rbsw_if.window                        link,
	// Flash array
	output logic [`RBSW_FLASH_AW-1:0]     flash_addr_o,
	output logic                          flash_rd_o,
	input  logic [7:0]                    flash_rdata_i,
	// Status
	output logic [2:0]                    bank_o,
	output logic                          bank_bad_o,
	output logic                          bank_changed_o,
	output logic                          window_hit_o
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	localparam logic [2:0] BANK_LIMIT = 3'(BANK_COUNT);

	// Registered state
	logic [2:0]                bank_r;
	logic                      bank_bad_r;
	logic                      bank_changed_r;
	logic                      s1_valid_r;
	logic                      s1_flash_r;
	logic                      s1_reg_r;
	logic                      s1_write_r;
	logic                      s1_win_r;
	logic [7:0]                s1_regval_r;
	logic [`RBSW_FLASH_AW-1:0] s1_addr_r;
	logic                      rsp_valid_r;
	logic [7:0]                rsp_rdata_r;

	// Decode
	logic                      take;
	logic                      hit_reg;
	logic                      hit_common;
	logic                      hit_win;
	logic [`RBSW_FLASH_AW-1:0] map_addr;
	logic [2:0]                wr_bank;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// A request is taken on any enabled edge with valid high
	// ce_i low freezes every flop
	assign take       = ce_i & link.req_valid;
	assign hit_reg    = (link.req_addr == `RBSW_BANK_REG_ADDR);
	assign hit_common = (link.req_addr <= `RBSW_COMMON_LAST);
	assign hit_win    = (link.req_addr >= `RBSW_WIN_FIRST) &&
	                    (link.req_addr <= `RBSW_WIN_LAST);

	// Only the bank field of the written byte is kept
	assign wr_bank = link.req_wdata[`RBSW_BANK_MSB:`RBSW_BANK_LSB];

	// Codes 6 and 7 would run past a 128 KB array and wrap;
	// the CPU end refuses them, bank_bad_o flags the rest
	// Window offset rides on top of the bank base; common area maps flat
	always_comb begin
		if (hit_win) begin
			map_addr = `RBSW_FLASH_WIN_BASE
			         + `RBSW_FLASH_AW'({bank_r, {`RBSW_WIN_OFS_BITS{1'b0}}})
			         + `RBSW_FLASH_AW'(link.req_addr[`RBSW_WIN_OFS_BITS-1:0]);
		end else begin
			map_addr = `RBSW_FLASH_AW'(link.req_addr);
		end
	end

	// ------------------------------------------------------------------
	// Bank select register
	// ------------------------------------------------------------------
	// Written by any byte store to the register address; prohibited codes
	// are still stored so software reads back what it wrote, but flagged
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bank_r <= `RBSW_BANK_RESET;
		end else if (take && link.req_write && hit_reg) begin
			bank_r <= wr_bank;
		end
	end

	// Prohibited code flag loads with the bank, from a flop
	// so the status pin never glitches on decode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bank_bad_r <= 1'b0;
		end else if (take && link.req_write && hit_reg) begin
			bank_bad_r <= (wr_bank >= BANK_LIMIT);
		end
	end

	// Pulse when a store really changes the selected bank
	// Status only, read by nothing inside
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bank_changed_r <= 1'b0;
		end else if (ce_i) begin
			bank_changed_r <= take && link.req_write && hit_reg && (wr_bank != bank_r);
		end
	end

	// ------------------------------------------------------------------
	// Stage 1: flash address and register snapshot
	// ------------------------------------------------------------------
	// The address uses the bank in force at the take edge, so an access
	// right after a bank store already sees the new bank
	// Flags drop to zero on enabled edges without a take
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_valid_r <= 1'b0;
			s1_flash_r <= 1'b0;
			s1_reg_r   <= 1'b0;
			s1_write_r <= 1'b0;
			s1_win_r   <= 1'b0;
		end else if (ce_i) begin
			s1_valid_r <= take;
			s1_flash_r <= take && !link.req_write && (hit_common || hit_win);
			s1_reg_r   <= take && hit_reg;
			s1_write_r <= take && link.req_write;
			s1_win_r   <= take && hit_win;
		end
	end

	// Vector reads take the same path as fetches: no automatic switching,
	// the handler comes from whichever bank is selected now
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_addr_r   <= '0;
			s1_regval_r <= 8'h00;
		end else if (ce_i && take) begin
			s1_addr_r   <= map_addr;
			s1_regval_r <= {`RBSW_BANK_PAD, bank_r};
		end
	end

	// ------------------------------------------------------------------
	// Stage 2: answer to the CPU
	// ------------------------------------------------------------------
	// Every request answers two enabled edges after it is taken; writes
	// and unmapped addresses answer zero
	// The array has a whole cycle to answer flash_addr_o
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_valid_r <= 1'b0;
			rsp_rdata_r <= 8'h00;
		end else if (ce_i) begin
			rsp_valid_r <= s1_valid_r;
			if (s1_valid_r) begin
				if (s1_write_r) begin
					rsp_rdata_r <= 8'h00;
				end else if (s1_reg_r) begin
					rsp_rdata_r <= s1_regval_r;
				end else if (s1_flash_r) begin
					rsp_rdata_r <= flash_rdata_i;
				end else begin
					rsp_rdata_r <= 8'h00;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Link outputs straight from flops
	assign link.rsp_valid = rsp_valid_r;
	assign link.rsp_rdata = rsp_rdata_r;
	assign flash_addr_o   = s1_addr_r;
	assign flash_rd_o     = s1_valid_r & s1_flash_r;
	assign bank_o         = bank_r;
	// Codes past the fitted banks point outside the array
	assign bank_bad_o     = bank_bad_r;
	assign bank_changed_o = bank_changed_r;
	assign window_hit_o   = s1_win_r;

endmodule : rbsw_bank_window

/* File: rbsw_cpu_port.sv */
/*
 * CPU end of the banked window link: forwards core accesses one at a
 * time, refuses bank stores and fetches that would break the window,
 * and keeps a shadow and one saved copy of the selected bank.
 * Assumes the window end answers every forwarded request exactly once.
 */
`timescale 1ns/1ps
`include "rbsw_defines.svh"

module rbsw_cpu_port #(
	parameter int BANK_COUNT = `RBSW_BANKS_LARGE
) (
	// Clock, reset, enable
	input  logic                 clk_i,
	input  logic                 rst_i,
	input  logic                 ce_i,
	// Window link
	rbsw_if.cpu                  link,
	// Core request
	input  logic                 core_req_i,
	input  logic [15:0]          core_addr_i,
	input  logic                 core_write_i,
	input  logic [7:0]           core_wdata_i,
	input  rbsw_pkg::rbsw_kind_t core_kind_i,
	input  logic [15:0]          core_pc_i,
	output logic                 core_busy_o,
	// Core answer
	output logic                 core_rsp_valid_o,
	output logic [7:0]           core_rdata_o,
	output logic                 core_refused_o,
	// Bank save and restore
	input  logic                 core_save_i,
	input  logic                 core_restore_i,
	output logic [2:0]           bank_shadow_o,
	output logic [2:0]           bank_saved_o
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	localparam logic [2:0] BANK_LIMIT = 3'(BANK_COUNT);

	rbsw_pkg::rbsw_state_t state_r;
	rbsw_pkg::rbsw_kind_t  kind_r;
	logic        req_valid_r;
	logic [15:0] addr_r;
	logic        write_r;
	logic [7:0]  wdata_r;
	logic [2:0]  shadow_r;
	logic [2:0]  saved_r;
	logic        rsp_valid_r;
	logic [7:0]  rdata_r;
	logic        refused_r;

	logic        idle;
	logic        start;
	logic [15:0] c_addr;
	logic        c_write;
	logic [7:0]  c_wdata;
	logic        bank_store;
	logic        pc_in_win;
	logic        refuse;

	// ------------------------------------------------------------------
	// Candidate request; a restore overrides the core this cycle
	// ------------------------------------------------------------------
	assign idle    = (state_r == rbsw_pkg::RBSW_ST_IDLE);
	assign start   = ce_i && idle && (core_restore_i || core_req_i);
	assign c_addr  = core_restore_i ? `RBSW_BANK_REG_ADDR : core_addr_i;
	assign c_write = core_restore_i | core_write_i;
	assign c_wdata = core_restore_i ? {`RBSW_BANK_PAD, saved_r} : core_wdata_i;

	assign bank_store = c_write && (c_addr == `RBSW_BANK_REG_ADDR);
	assign pc_in_win  = (core_pc_i >= `RBSW_WIN_FIRST) && (core_pc_i <= `RBSW_WIN_LAST);

	// Stores of prohibited codes, stores from inside the window and
	// fetches continuing across 8000h outside bank 0 never leave here
	always_comb begin
		refuse = 1'b0;
		if (bank_store && (c_wdata[`RBSW_BANK_MSB:`RBSW_BANK_LSB] >= BANK_LIMIT)) begin
			refuse = 1'b1;
		end
		if (bank_store && pc_in_win) begin
			refuse = 1'b1;
		end
		if (!core_restore_i && (core_kind_i == rbsw_pkg::RBSW_KIND_FETCH) &&
		    (c_addr == `RBSW_WIN_FIRST) && (core_pc_i <= `RBSW_COMMON_LAST) &&
		    (shadow_r != `RBSW_BANK_RESET)) begin
			refuse = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer: one outstanding request
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r     <= rbsw_pkg::RBSW_ST_IDLE;
			req_valid_r <= 1'b0;
		end else if (ce_i) begin
			unique case (state_r)
				rbsw_pkg::RBSW_ST_IDLE: begin
					req_valid_r <= start && !refuse;
					if (start && !refuse) begin
						state_r <= rbsw_pkg::RBSW_ST_WAIT;
					end
				end
				rbsw_pkg::RBSW_ST_WAIT: begin
					req_valid_r <= 1'b0;
					if (link.rsp_valid) begin
						state_r <= rbsw_pkg::RBSW_ST_IDLE;
					end
				end
				default: begin
					state_r     <= rbsw_pkg::RBSW_ST_IDLE;
					req_valid_r <= 1'b0;
				end
			endcase
		end
	end

	// Request fields held for the window end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_r  <= 16'h0000;
			write_r <= 1'b0;
			wdata_r <= 8'h00;
			kind_r  <= rbsw_pkg::RBSW_KIND_FETCH;
		end else if (start && !refuse) begin
			addr_r  <= c_addr;
			write_r <= c_write;
			wdata_r <= c_wdata;
			kind_r  <= core_restore_i ? rbsw_pkg::RBSW_KIND_DATA : core_kind_i;
		end
	end

	// ------------------------------------------------------------------
	// Bank shadow and saved copy
	// ------------------------------------------------------------------
	// Shadow follows forwarded stores; a save in the same cycle keeps the
	// older value, which is the bank to come back to
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shadow_r <= `RBSW_BANK_RESET;
			saved_r  <= `RBSW_BANK_RESET;
		end else if (ce_i) begin
			if (start && !refuse && bank_store) begin
				shadow_r <= c_wdata[`RBSW_BANK_MSB:`RBSW_BANK_LSB];
			end
			if (core_save_i) begin
				saved_r <= shadow_r;
			end
		end
	end

	// ------------------------------------------------------------------
	// Answer to the core
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_valid_r <= 1'b0;
			rdata_r     <= 8'h00;
			refused_r   <= 1'b0;
		end else if (ce_i) begin
			rsp_valid_r <= !idle && link.rsp_valid;
			refused_r   <= start && refuse;
			if (!idle && link.rsp_valid) begin
				rdata_r <= link.rsp_rdata;
			end
		end
	end

	assign link.req_valid   = req_valid_r;
	assign link.req_addr    = addr_r;
	assign link.req_write   = write_r;
	assign link.req_wdata   = wdata_r;
	assign link.req_kind    = kind_r;
	assign core_busy_o      = !idle || core_restore_i;
	assign core_rsp_valid_o = rsp_valid_r;
	assign core_rdata_o     = rdata_r;
	assign core_refused_o   = refused_r;
	assign bank_shadow_o    = shadow_r;
	assign bank_saved_o     = saved_r;

endmodule : rbsw_cpu_port

/* File: rbsw_defines.svh */
/*
 * Constants of the banked program-memory window: bank select register
 * address, field layout, reset value and the address map of the window.
 * Assumes a 16-bit CPU address space and a flash array of at most 128 KB.
 */
`ifndef RBSW_DEFINES_SVH
`define RBSW_DEFINES_SVH

// ----------------------------------------------------------------------
// Bank select register
// ----------------------------------------------------------------------
`define RBSW_BANK_REG_ADDR   16'hfff3
`define RBSW_BANK_RESET      3'h0
`define RBSW_BANK_MSB        2
`define RBSW_BANK_LSB        0
`define RBSW_BANK_PAD        5'h00

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define RBSW_COMMON_LAST     16'h7fff
`define RBSW_WIN_FIRST       16'h8000
`define RBSW_WIN_LAST        16'hbfff
`define RBSW_WIN_OFS_BITS    14
`define RBSW_FLASH_WIN_BASE  17'h08000
`define RBSW_FLASH_AW        17

// ----------------------------------------------------------------------
// Variants
// ----------------------------------------------------------------------
`define RBSW_BANKS_SMALL     4
`define RBSW_BANKS_LARGE     6

`endif

/* File: rbsw_if.sv */
/*
 * Link between the CPU core end and the banked window end.
 * Assumes both ends run on one clock; the clock is not carried here.
 */
`timescale 1ns/1ps

interface rbsw_if;
	logic                 req_valid;
	logic [15:0]          req_addr;
	logic                 req_write;
	logic [7:0]           req_wdata;
	rbsw_pkg::rbsw_kind_t req_kind;
	logic                 rsp_valid;
	logic [7:0]           rsp_rdata;

	modport window (
		input  req_valid, req_addr, req_write, req_wdata, req_kind,
		output rsp_valid, rsp_rdata
	);

	modport cpu (
		output req_valid, req_addr, req_write, req_wdata, req_kind,
		input  rsp_valid, rsp_rdata
	);
endinterface : rbsw_if

/* File: rbsw_pkg.sv */
/*
 * Types of the banked window link: the access kinds both ends share, and the CPU end states.
 * Assumes rbsw_defines.svh supplies all numeric constants.
 */
package rbsw_pkg;

	// ------------------------------------------------------------------
	// Access kinds
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		RBSW_KIND_FETCH  = 2'h0,
		RBSW_KIND_DATA   = 2'h1,
		RBSW_KIND_VECTOR = 2'h2
	} rbsw_kind_t;

	// ------------------------------------------------------------------
	// CPU end states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		RBSW_ST_IDLE = 2'h1,
		RBSW_ST_WAIT = 2'h2
	} rbsw_state_t;

endpackage : rbsw_pkg

/* File: rbsw_properties.sv */
/*
 * Link checker for the banked window: answer timing, select register
 * readback and the codes the CPU end lets through to the window end.
 * Assumes both ends share clk_i and that ce_i drops only while the link is idle.
 */
`timescale 1ns/1ps

module rbsw_properties #(
	parameter int BANK_COUNT = 6
) (
	// Clock and reset
	input logic                 clk_i,
	input logic                 rst_i,
	// Link request
	input logic                 req_valid,
	input logic [15:0]          req_addr,
	input logic                 req_write,
	input logic [7:0]           req_wdata,
	input rbsw_pkg::rbsw_kind_t req_kind,
	// Link answer
	input logic                 rsp_valid,
	input logic [7:0]           rsp_rdata
);
	// ------------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------------
	logic       bank_wr;
	logic       bank_rd;
	logic [2:0] bank_r;

	// Store and read of the select register as seen on the wire
	assign bank_wr = req_valid && req_write && (req_addr == 16'hfff3);
	assign bank_rd = req_valid && !req_write && (req_addr == 16'hfff3);

	// Shadow of the bank; prohibited codes are stored too, like the window end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bank_r <= 3'h0;
		end else if (bank_wr) begin
			bank_r <= req_wdata[2:0];
		end
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Bank sampled at the take edge, so a store just before is already seen
	property readback_p;
		logic [2:0] b;
		(bank_rd, b = bank_r) |-> ##2 (rsp_valid && rsp_rdata == {5'h00, b});
	endproperty

	rsp_latency_a: assert property (req_valid |-> ##2 rsp_valid)
		else $error("answer not two cycles after request");
	rsp_cause_a: assert property (rsp_valid |-> $past(req_valid, 2))
		else $error("answer without request");
	rsp_single_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	bank_readback_a: assert property (readback_p)
		else $error("select register readback wrong");
	upper_zero_a: assert property (bank_rd |-> ##2 rsp_rdata[7:3] == 5'h00)
		else $error("select register upper bits not zero");
	write_zero_a: assert property (req_valid && req_write |-> ##2 rsp_rdata == 8'h00)
		else $error("write answered with data");
	code_allowed_a: assert property (bank_wr |-> req_wdata[2:0] < BANK_COUNT)
		else $error("prohibited bank code forwarded");
	one_outstanding_a: assert property (req_valid |=> !req_valid [*3])
		else $error("second request while one outstanding");
	rdata_hold_a: assert property (!rsp_valid |-> $stable(rsp_rdata))
		else $error("read data changed between answers");

	// Main scenarios reached
	cover property (bank_wr);
	cover property (req_valid && !req_write && req_addr[15:14] == 2'h2);
	cover property (req_valid && req_kind == rbsw_pkg::RBSW_KIND_VECTOR);
endmodule : rbsw_properties

/* File: tb.sv */
/*
 * Testbench joining the CPU end and the window end, with a second window
 * end of the small variant driven directly to store a prohibited code.
 * Assumes a flash array that answers combinationally from its address.
 */
`timescale 1ns/1ps

module tb;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic                 clk_i;
	logic                 rst_i;
	logic                 ce_i;
	logic                 core_req_i;
	logic [15:0]          core_addr_i;
	logic                 core_write_i;
	logic [7:0]           core_wdata_i;
	rbsw_pkg::rbsw_kind_t core_kind_i;
	logic [15:0]          core_pc_i;
	logic                 core_save_i;
	logic                 core_restore_i;
	logic                 core_rsp_valid_o;
	logic                 core_refused_o;
	logic [7:0]           core_rdata_o;
	logic [2:0]           bank_shadow_o;
	logic [2:0]           bank_saved_o;
	logic [2:0]           bank_o;
	logic [2:0]           bank_number_bit2_o;
	logic                 bank_bad_o;
	logic                 bank_number_bit2_bad_o;
	logic [16:0]          flash_addr_o;
	logic [16:0]          flash2_addr_o;
	int                   errors;
	int                   n_tests;
	logic [31:0]          lfsr_r;
	logic [2:0]           exp_bank;
	logic [8:0]           notes_q[$];

	rbsw_if link();
	rbsw_if link2();

	// Flash contents depend on bank bits so a wrong bank shows up
	function automatic logic [7:0] flash_byte(input logic [16:0] a);
		flash_byte = a[7:0] ^ {a[16:14], a[12:8]};
	endfunction : flash_byte

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next

	// ------------------------------------------------------------------
	// Design and checker
	// ------------------------------------------------------------------
	rbsw_cpu_port #(.BANK_COUNT(6)) i_rbsw_cpu_port (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .link(link.cpu), .core_req_i(core_req_i), .core_addr_i(core_addr_i),
		.core_write_i(core_write_i), .core_wdata_i(core_wdata_i), .core_kind_i(core_kind_i),
		.core_pc_i(core_pc_i), .core_busy_o(), .core_rsp_valid_o(core_rsp_valid_o),
		.core_rdata_o(core_rdata_o), .core_refused_o(core_refused_o),
		.core_save_i(core_save_i), .core_restore_i(core_restore_i),
		.bank_shadow_o(bank_shadow_o), .bank_saved_o(bank_saved_o));
	rbsw_bank_window #(.BANK_COUNT(6)) i_rbsw_bank_window (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .link(link.window), .flash_addr_o(flash_addr_o), .flash_rd_o(),
		.flash_rdata_i(flash_byte(flash_addr_o)), .bank_o(bank_o), .bank_bad_o(bank_bad_o),
		.bank_changed_o(), .window_hit_o());
	rbsw_bank_window #(.BANK_COUNT(4)) i_rbsw_bank_window_small (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(ce_i), .link(link2.window), .flash_addr_o(flash2_addr_o),
		.flash_rd_o(), .flash_rdata_i(flash_byte(flash2_addr_o)), .bank_o(bank_number_bit2_o),
		.bank_bad_o(bank_number_bit2_bad_o), .bank_changed_o(), .window_hit_o());
	rbsw_properties #(.BANK_COUNT(6)) i_rbsw_properties (.clk_i(clk_i), .rst_i(rst_i),
		.req_valid(link.req_valid), .req_addr(link.req_addr), .req_write(link.req_write),
		.req_wdata(link.req_wdata), .req_kind(link.req_kind), .rsp_valid(link.rsp_valid),
		.rsp_rdata(link.rsp_rdata));

	// ------------------------------------------------------------------
	// Compare and report
	// ------------------------------------------------------------------
	task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t read data %h expected %h", $time, got, exp);
		end
	endtask : check_data

	task automatic check_bank(input logic [2:0] got, input logic [2:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t bank %h expected %h", $time, got, exp);
		end
	endtask : check_bank

	task automatic check_flag(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : check_flag

	task automatic finish_test;
		if (errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	// Expected answer; bit 8 marks a refusal by the CPU end
	function automatic logic [8:0] expect_of(input logic [15:0] a, input logic w,
		input logic [7:0] d, input rbsw_pkg::rbsw_kind_t k, input logic [15:0] pc);
		logic [16:0] fa;
		fa = (a < 16'h8000) ? {1'b0, a} : 17'h08000 + {exp_bank, a[13:0]};
		if (w && a == 16'hfff3 && (d[2:0] > 3'h5 || pc[15:14] == 2'h2)) return 9'h100;
		if (!w && k == rbsw_pkg::RBSW_KIND_FETCH && a == 16'h8000 && pc < 16'h8000
			&& exp_bank != 3'h0) return 9'h100;
		if (w) return 9'h000;
		if (a == 16'hfff3) return {6'h00, exp_bank};
		if (a < 16'hc000) return {1'b0, flash_byte(fa)};
		return 9'h000;
	endfunction : expect_of

	// Bounded wait for an answer or a refusal of the CPU end
	task automatic wait_answer;
		int i;
		for (i = 0; i < 20; i++) begin
			@(negedge clk_i);
			if (core_rsp_valid_o === 1'b1 || core_refused_o === 1'b1) break;
		end
		if (i == 20) begin
			errors++;
			$display("[ERR] %0t no answer from core port", $time);
			finish_test();
		end
	endtask : wait_answer

	// One core access; the note goes in before the request is driven
	task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d,
		input rbsw_pkg::rbsw_kind_t k, input logic [15:0] pc);
		logic [8:0] e;
		e = expect_of(a, w, d, k, pc);
		notes_q.push_back(e);
		if (!e[8] && w && a == 16'hfff3) exp_bank = d[2:0];
		@(posedge clk_i);
		core_req_i <= 1'b1;
		core_addr_i <= a;
		core_write_i <= w;
		core_wdata_i <= d;
		core_kind_i <= k;
		core_pc_i <= pc;
		@(posedge clk_i);
		core_req_i <= 1'b0;
		wait_answer();
		check_bank(bank_o, exp_bank);
	endtask : access

	// Store straight into the small window end, bypassing the CPU end
	task automatic drive_small(input logic [7:0] d);
		@(posedge clk_i);
		link2.req_valid <= 1'b1;
		link2.req_wdata <= d;
		@(posedge clk_i);
		link2.req_valid <= 1'b0;
		@(negedge clk_i);
	endtask : drive_small

	// ------------------------------------------------------------------
	// Clock, watcher and main sequence
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Each answer or refusal takes the oldest note
	initial begin : watch
		logic [8:0] e;
		forever begin
			@(negedge clk_i);
			if (core_rsp_valid_o === 1'b1 || core_refused_o === 1'b1) begin
				e = (notes_q.size() > 0) ? notes_q.pop_front() : 9'h1ff;
				check_flag(core_refused_o, e[8]);
				if (!e[8]) check_data(core_rdata_o, e[7:0]);
			end
		end
	end

	initial begin : main
		int i;
		rst_i = 1'b1;
		ce_i = 1'b1;
		core_req_i = 1'b0;
		core_addr_i = 16'h0000;
		core_write_i = 1'b0;
		core_wdata_i = 8'h00;
		core_kind_i = rbsw_pkg::RBSW_KIND_DATA;
		core_pc_i = 16'h7000;
		core_save_i = 1'b0;
		core_restore_i = 1'b0;
		link2.req_valid = 1'b0;
		link2.req_addr = 16'hfff3;
		link2.req_write = 1'b1;
		link2.req_wdata = 8'h00;
		link2.req_kind = rbsw_pkg::RBSW_KIND_DATA;
		errors = 0;
		n_tests = 0;
		exp_bank = 3'h0;
		lfsr_r = 32'hd9fd;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		access(16'hfff3, 1'b0, 8'h00, rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
		// Every bank, junk in the upper bits, window edges and a vector
		for (i = 0; i < 6; i++) begin
			access(16'hfff3, 1'b1, 8'hf8 | i[7:0], rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
			access(16'hfff3, 1'b0, 8'h00, rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
			access(16'h8000, 1'b0, 8'h00, rbsw_pkg::RBSW_KIND_FETCH, 16'h8000);
			access(16'hbfff, 1'b0, 8'h00, rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
			access(16'h9abc, 1'b0, 8'h00, rbsw_pkg::RBSW_KIND_VECTOR, 16'h7000);
		end
		check_flag(bank_bad_o, 1'b0);
		// Refused stores: prohibited codes, store from inside the window
		access(16'hfff3, 1'b1, 8'h06, rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
		access(16'hfff3, 1'b1, 8'h07, rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
		access(16'hfff3, 1'b1, 8'h01, rbsw_pkg::RBSW_KIND_DATA, 16'h8100);
		// Straddling fetch refused in bank 5, taken in bank 0
		access(16'h8000, 1'b0, 8'h00, rbsw_pkg::RBSW_KIND_FETCH, 16'h7fff);
		access(16'hfff3, 1'b1, 8'h00, rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
		access(16'h8000, 1'b0, 8'h00, rbsw_pkg::RBSW_KIND_FETCH, 16'h7fff);
		// Save bank 2, move to bank 4, restore
		access(16'hfff3, 1'b1, 8'h02, rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
		@(posedge clk_i);
		core_save_i <= 1'b1;
		@(posedge clk_i);
		core_save_i <= 1'b0;
		access(16'hfff3, 1'b1, 8'h04, rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
		check_bank(bank_saved_o, 3'h2);
		// Frozen cycles: neither the save nor the request may act
		@(posedge clk_i);
		ce_i <= 1'b0;
		core_save_i <= 1'b1;
		core_req_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		ce_i <= 1'b1;
		core_save_i <= 1'b0;
		core_req_i <= 1'b0;
		@(negedge clk_i);
		check_bank(bank_saved_o, 3'h2);
		check_bank(bank_o, 3'h4);
		notes_q.push_back(9'h000);
		exp_bank = 3'h2;
		@(posedge clk_i);
		core_restore_i <= 1'b1;
		@(posedge clk_i);
		core_restore_i <= 1'b0;
		wait_answer();
		check_bank(bank_o, 3'h2);
		check_bank(bank_shadow_o, 3'h2);
		// Random bank stores and reads over the whole address space
		for (i = 0; i < 80; i++) begin
			lfsr_r = lfsr_next(lfsr_r);
			if (lfsr_r[2:0] == 3'h0) begin
				access(16'hfff3, 1'b1, {5'h00, lfsr_r[10:8] % 3'h6},
					rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
			end else begin
				access(lfsr_r[31:16], 1'b0, 8'h00, lfsr_r[4] ? rbsw_pkg::RBSW_KIND_FETCH
					: rbsw_pkg::RBSW_KIND_DATA, 16'h7000);
			end
		end
		// Small variant keeps code 4 but flags it, code 3 is clean
		drive_small(8'h04);
		check_flag(bank_number_bit2_bad_o, 1'b1);
		check_bank(bank_number_bit2_o, 3'h4);
		drive_small(8'h03);
		check_flag(bank_number_bit2_bad_o, 1'b0);
		repeat (4) @(posedge clk_i);
		finish_test();
	end
endmodule : tb
